// *** core/nvmps_page_store.sv ***
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [RL1] locked: factory and user pages read invalid
// [RL2] pages two to fifteen always readable
// [RL3] codes b0 to bf return page bytes
// [RL4] host programs read count first
// [RL5] first read byte comes from offset
// [RL6] one read transfer at most 256 bytes
// [RL7] page writes accepted only while unlocked
// [RL8] writes to settings pages are refused
// [RL9] writes start at offset, then sequential
// [RL10] one write transfer at most 256 bytes
// [RL11] power-up leaves the memory locked
// [RL12] two correct passwords unlock, flag bit six
// [RL13] wrong password locks and clears flag
// [RL14] correct then new value changes password
// [RL15] user page loaded at power-up and restore
// [RL16] factory restore loads page zero, password ff
// [RL17] nothing ever stores into factory page
// [RL18] store needs unlock, erases, saves, busy
// [RL19] stored image ends with ones count
// [RL20] load compares ones count, fault bit five
// [RL21] checksum read gives last load count
// [RL22] checksum is eight bit wrapping counter
// [RL23] erase pages two to fifteen by number
// [RL24] host waits after erase before commands
// [RL25] erase sets ones, writes only clear bits
// [RL26] low code bits select the page
module nvmps_page_store #(
  parameter int unsigned BUSY_CYCLES = nvmps_pkg::BUSY_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire nvmps_pkg::nvmps_req_t req,
  output logic req_ready,
  output logic req_nack,
  output logic rsp_valid,
  output nvmps_pkg::nvmps_rsp_t rsp,
  input wire logic rsp_ready,
  input wire logic [nvmps_pkg::SET_BITS-1:0] settings_cur,
  output logic [nvmps_pkg::SET_BITS-1:0] settings,
  output logic settings_load
);

  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_STORE, ST_LOAD, ST_WAIT} nvmps_state_t;

  function automatic logic [7:0] ones8(input logic [7:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 8; i++) begin
      n = n + {7'h00, v[i]};
    end
    return n;
  endfunction

  logic [7:0] mem_q [0:nvmps_pkg::MEM_BYTES-1];
  nvmps_state_t st_q;
  logic req_ready_q, req_nack_q, unlocked_q, pw_hit_q, fault_q, store_pend_q, settings_load_q;
  logic [7:0] pw_q, rd_cnt_q, csum_q, acc_q;
  logic [15:0] off_q;
  logic [8:0] wr_idx_q;
  logic [9:0] walk_q;
  logic [3:0] op_page_q;
  nvmps_pkg::nvmps_tmr_t tmr_q;
  logic [nvmps_pkg::SET_BITS-1:0] settings_q;
  logic rd_act_q;
  logic [15:0] rd_code_q;
  logic [8:0] rd_ptr_q, rd_left_q;
  logic out_v_q, skid_v_q;
  nvmps_pkg::nvmps_rsp_t out_q, skid_q;

  logic take, is_page, rd_is_page, pw_ok, push, pop;
  logic nack_d, pg_wr, start_erase, start_store, start_load, start_rd;
  logic [3:0] req_page, load_page;
  logic [8:0] wr_idx;
  logic [12:0] wr_addr;
  logic [7:0] rd_byte, flags, store_byte, load_byte;

  assign req_ready = req_ready_q;
  assign req_nack = req_nack_q;
  assign rsp_valid = out_v_q;
  assign rsp = out_q;
  assign settings = settings_q;
  assign settings_load = settings_load_q;

  // request decode; page picked from the low code bits
  assign take = req_valid && req_ready_q;
  assign is_page = (req.code >= nvmps_pkg::OFF_PAGE_DATA_LO) && (req.code <= nvmps_pkg::OFF_PAGE_DATA_HI);
  assign req_page = req.code[3:0]; // RL26
  assign wr_idx = req.first ? 9'h000 : wr_idx_q;
  assign wr_addr = {req_page, 9'(off_q[8:0] + wr_idx)}; // RL9
  assign pw_ok = (req.data == pw_q);

  // classify each accepted beat into one action or a refusal
  always_comb begin
    nack_d = 1'b0;
    pg_wr = 1'b0;
    start_erase = 1'b0;
    start_store = 1'b0;
    start_load = 1'b0;
    start_rd = 1'b0;
    load_page = nvmps_pkg::USER_PAGE;
    if (take) begin
      unique case (req.kind)
        nvmps_pkg::NVMPS_BEAT_WRITE: begin
          if (is_page) begin
            if (req_page < nvmps_pkg::FIRST_OPEN_PAGE) begin
              nack_d = 1'b1; // RL8
            end else if (!unlocked_q || wr_idx >= nvmps_pkg::MAX_BLOCK_BYTES) begin
              nack_d = 1'b1; // RL7 RL10
            end else begin
              pg_wr = 1'b1;
            end
          end else if (req.code == nvmps_pkg::OFF_PAGE_ERASE) begin
            // settings pages and out-of-range numbers are refused
            if (unlocked_q && req.first && req.data[7:4] == 4'h0 && req.data[3:0] >= nvmps_pkg::FIRST_OPEN_PAGE) begin
              start_erase = 1'b1; // RL23
            end else begin
              nack_d = 1'b1;
            end
          end else if (req.code != nvmps_pkg::OFF_RD_COUNT && req.code != nvmps_pkg::OFF_BYTE_OFFSET &&
                       req.code != nvmps_pkg::OFF_PASSWORD) begin
            nack_d = 1'b1;
          end
        end
        nvmps_pkg::NVMPS_BEAT_SEND: begin
          if (req.code == nvmps_pkg::CMD_RESTORE_FACTORY) begin
            start_load = 1'b1; // RL16
            load_page = nvmps_pkg::FACTORY_PAGE;
          end else if (req.code == nvmps_pkg::CMD_RESTORE_USER) begin
            start_load = 1'b1; // RL15
          end else if (req.code == nvmps_pkg::CMD_STORE_USER && unlocked_q) begin
            start_store = 1'b1; // RL18
          end else begin
            nack_d = 1'b1;
          end
        end
        nvmps_pkg::NVMPS_BEAT_READ: begin
          start_rd = 1'b1;
        end
        default: begin
          nack_d = 1'b1;
        end
      endcase
    end
  end

  // ready drops for at least one cycle after every accepted beat so state settles first
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      req_ready_q <= 1'b0;
      req_nack_q <= 1'b0;
    end else begin
      req_ready_q <= !take && (st_q == ST_IDLE) && !rd_act_q; // RL18 RL24
      req_nack_q <= nack_d;
    end
  end

  // read count, offset and write byte index
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_cnt_q <= nvmps_pkg::RD_COUNT_RESET;
      off_q <= nvmps_pkg::OFFSET_RESET;
      wr_idx_q <= 9'h000;
    end else if (take && req.kind == nvmps_pkg::NVMPS_BEAT_WRITE) begin
      wr_idx_q <= (wr_idx == 9'h1ff) ? wr_idx : 9'(wr_idx + 9'h001);
      if (req.code == nvmps_pkg::OFF_RD_COUNT && wr_idx == 9'h000) begin
        rd_cnt_q <= req.data; // RL4
      end
      // offset pairs low byte first, extra bytes are dropped
      if (req.code == nvmps_pkg::OFF_BYTE_OFFSET && wr_idx == 9'h000) begin
        off_q[7:0] <= req.data; // RL5
      end
      if (req.code == nvmps_pkg::OFF_BYTE_OFFSET && wr_idx == 9'h001) begin
        off_q[15:8] <= req.data;
      end
    end
  end

  // lock state and password; any other beat breaks a password pair
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      unlocked_q <= 1'b0; // RL11
      pw_hit_q <= 1'b0;
      pw_q <= nvmps_pkg::PW_POWERUP;
    end else if (take && req.kind == nvmps_pkg::NVMPS_BEAT_WRITE && req.code == nvmps_pkg::OFF_PASSWORD) begin
      if (pw_ok) begin
        pw_hit_q <= 1'b1;
        if (pw_hit_q) begin
          unlocked_q <= 1'b1; // RL12
        end
      end else if (unlocked_q && pw_hit_q) begin
        pw_q <= req.data; // RL14
        pw_hit_q <= 1'b0;
      end else begin
        unlocked_q <= 1'b0; // RL13
        pw_hit_q <= 1'b0;
      end
    end else if (take) begin
      pw_hit_q <= 1'b0;
      if (start_load && load_page == nvmps_pkg::FACTORY_PAGE) begin
        pw_q <= nvmps_pkg::PW_FACTORY; // RL16
      end
    end
  end

  // store always targets the user page, so the factory page is never saved into
  assign store_byte = (walk_q == nvmps_pkg::WALK_CSUM) ? acc_q : settings_cur[8 * walk_q[3:0] +: 8]; // RL17 RL19
  assign load_byte = mem_q[{op_page_q, walk_q[8:0]}];

  // the array only ever clears bits except during erase
  always_ff @(posedge ref_clk) begin
    if (st_q == ST_ERASE) begin
      mem_q[{op_page_q, walk_q[8:0]}] <= nvmps_pkg::ERASED_BYTE; // RL25
    end else if (st_q == ST_STORE) begin
      mem_q[{nvmps_pkg::USER_PAGE, walk_q[8:0]}] <= mem_q[{nvmps_pkg::USER_PAGE, walk_q[8:0]}] & store_byte;
    end else if (pg_wr) begin
      mem_q[wr_addr] <= mem_q[wr_addr] & req.data; // RL25
    end
  end

  // erase, store and settings download sequencer; power-up starts with a download
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= ST_LOAD; // RL15
      op_page_q <= nvmps_pkg::USER_PAGE;
      walk_q <= 10'h000;
      acc_q <= 8'h00;
      tmr_q <= '0;
      store_pend_q <= 1'b0;
      fault_q <= 1'b0;
      csum_q <= 8'h00;
      settings_q <= '0;
      settings_load_q <= 1'b0;
    end else begin
      settings_load_q <= 1'b0;
      if (tmr_q != '0) begin
        tmr_q <= tmr_q - 1'b1;
      end
      unique case (st_q)
        ST_IDLE: begin
          walk_q <= 10'h000;
          acc_q <= 8'h00;
          if (start_erase || start_store) begin
            st_q <= ST_ERASE; // RL18
            op_page_q <= start_store ? nvmps_pkg::USER_PAGE : req.data[3:0];
            store_pend_q <= start_store;
            tmr_q <= nvmps_pkg::nvmps_tmr_t'(BUSY_CYCLES - 1);
          end else if (start_load) begin
            st_q <= ST_LOAD;
            op_page_q <= load_page;
          end
        end
        ST_ERASE: begin
          walk_q <= (walk_q == nvmps_pkg::WALK_ERASE_LAST) ? 10'h000 : 10'(walk_q + 10'h001);
          if (walk_q == nvmps_pkg::WALK_ERASE_LAST) begin
            st_q <= store_pend_q ? ST_STORE : ST_WAIT;
          end
        end
        ST_STORE: begin
          walk_q <= 10'(walk_q + 10'h001);
          acc_q <= 8'(acc_q + ones8(store_byte)); // RL19 RL22
          if (walk_q == nvmps_pkg::WALK_CSUM) begin
            st_q <= ST_WAIT;
          end
        end
        ST_LOAD: begin
          walk_q <= 10'(walk_q + 10'h001);
          if (walk_q == nvmps_pkg::WALK_CSUM) begin
            fault_q <= (acc_q != load_byte); // RL20
            csum_q <= acc_q; // RL21
            settings_load_q <= 1'b1;
            st_q <= ST_IDLE;
          end else begin
            settings_q[8 * walk_q[3:0] +: 8] <= load_byte;
            acc_q <= 8'(acc_q + ones8(load_byte)); // RL22
          end
        end
        ST_WAIT: begin
          if (tmr_q == '0) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // read byte source for the current pointer
  assign rd_is_page = (rd_code_q >= nvmps_pkg::OFF_PAGE_DATA_LO) && (rd_code_q <= nvmps_pkg::OFF_PAGE_DATA_HI);
  always_comb begin
    flags = 8'h00;
    flags[nvmps_pkg::FLAG_UNLOCKED_BIT] = unlocked_q; // RL12
    flags[nvmps_pkg::FLAG_CSUM_FAULT_BIT] = fault_q; // RL20
    rd_byte = nvmps_pkg::INVALID_BYTE;
    if (rd_is_page) begin
      if (rd_code_q[3:0] >= nvmps_pkg::FIRST_OPEN_PAGE || unlocked_q) begin
        rd_byte = mem_q[{rd_code_q[3:0], rd_ptr_q}]; // RL1 RL2 RL3
      end
    end else if (rd_code_q == nvmps_pkg::OFF_CHECKSUM) begin
      rd_byte = csum_q; // RL21
    end else if (rd_code_q == nvmps_pkg::OFF_RD_COUNT) begin
      rd_byte = rd_cnt_q;
    end else if (rd_code_q == nvmps_pkg::OFF_BYTE_OFFSET) begin
      rd_byte = rd_ptr_q[0] ? off_q[15:8] : off_q[7:0];
    end else if (rd_code_q == nvmps_pkg::OFF_STATUS_FLAGS) begin
      rd_byte = flags;
    end
  end

  // read generator; a zero count means a full 256-byte block
  assign push = rd_act_q && !skid_v_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_act_q <= 1'b0;
      rd_code_q <= 16'h0000;
      rd_ptr_q <= 9'h000;
      rd_left_q <= 9'h000;
    end else if (start_rd) begin
      rd_act_q <= 1'b1;
      rd_code_q <= req.code;
      rd_ptr_q <= is_page ? off_q[8:0] : 9'h000; // RL5
      if (is_page) begin
        rd_left_q <= (rd_cnt_q == 8'h00) ? nvmps_pkg::MAX_BLOCK_BYTES : {1'b0, rd_cnt_q}; // RL4 RL6
      end else begin
        rd_left_q <= (req.code == nvmps_pkg::OFF_BYTE_OFFSET) ? 9'h002 : 9'h001;
      end
    end else if (push) begin
      rd_ptr_q <= 9'(rd_ptr_q + 9'h001); // wraps inside the page
      rd_left_q <= 9'(rd_left_q - 9'h001);
      if (rd_left_q == 9'h001) begin
        rd_act_q <= 1'b0;
      end
    end
  end

  // two-entry output buffer: the skid slot absorbs the byte in flight when the host stalls
  assign pop = out_v_q && rsp_ready;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      out_q <= '0;
      skid_q <= '0;
    end else if (pop || !out_v_q) begin
      if (skid_v_q) begin
        out_q <= skid_q;
        out_v_q <= 1'b1;
        skid_v_q <= 1'b0;
      end else begin
        out_q <= '{data: rd_byte, last: rd_left_q == 9'h001};
        out_v_q <= push;
      end
    end else if (push) begin
      skid_q <= '{data: rd_byte, last: rd_left_q == 9'h001};
      skid_v_q <= 1'b1;
    end
  end

  // helper for checking programmed bytes one cycle later
  logic prog_chk_q;
  logic [12:0] prog_addr_q;
  logic [7:0] prog_exp_q;
  always_ff @(posedge ref_clk) begin
    prog_chk_q <= pg_wr && !reset;
    prog_addr_q <= wr_addr;
    prog_exp_q <= mem_q[wr_addr] & req.data;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  low_page_lock_a: assert property (push && rd_is_page && rd_code_q[3:0] < nvmps_pkg::FIRST_OPEN_PAGE && !unlocked_q
    |-> rd_byte == nvmps_pkg::INVALID_BYTE) else $error("locked settings page read not invalid"); // RL1
  open_page_read_a: assert property (push && rd_is_page && rd_code_q[3:0] >= nvmps_pkg::FIRST_OPEN_PAGE
    |-> rd_byte == mem_q[{rd_code_q[3:0], rd_ptr_q}]) else $error("open page read wrong byte"); // RL2
  read_len_a: assert property (start_rd && is_page |=> rd_ptr_q == $past(off_q[8:0]) && rd_left_q != 9'h000
    && rd_left_q <= nvmps_pkg::MAX_BLOCK_BYTES) else $error("page read start wrong"); // RL6
  settings_wr_nack_a: assert property (take && req.kind == nvmps_pkg::NVMPS_BEAT_WRITE && is_page
    && req_page < nvmps_pkg::FIRST_OPEN_PAGE |=> req_nack_q) else $error("settings page write not refused"); // RL8
  locked_wr_nack_a: assert property (take && req.kind == nvmps_pkg::NVMPS_BEAT_WRITE && is_page && !unlocked_q
    |=> req_nack_q && !prog_chk_q) else $error("locked page write accepted"); // RL7
  program_byte_a: assert property (prog_chk_q |-> mem_q[prog_addr_q] == prog_exp_q)
    else $error("programmed byte wrong"); // RL25
  unlock_pair_a: assert property (take && req.kind == nvmps_pkg::NVMPS_BEAT_WRITE && req.code == nvmps_pkg::OFF_PASSWORD
    && pw_ok && pw_hit_q |=> unlocked_q && flags[nvmps_pkg::FLAG_UNLOCKED_BIT]) else $error("unlock failed"); // RL12
  wrong_pw_lock_a: assert property (take && req.kind == nvmps_pkg::NVMPS_BEAT_WRITE && req.code == nvmps_pkg::OFF_PASSWORD
    && !pw_ok && !(unlocked_q && pw_hit_q) |=> !unlocked_q) else $error("wrong password did not lock"); // RL13
  pw_change_a: assert property (take && req.kind == nvmps_pkg::NVMPS_BEAT_WRITE && req.code == nvmps_pkg::OFF_PASSWORD
    && !pw_ok && unlocked_q && pw_hit_q |=> pw_q == $past(req.data) && unlocked_q) else $error("password not changed"); // RL14
  factory_restore_a: assert property (start_load && load_page == nvmps_pkg::FACTORY_PAGE
    |=> pw_q == nvmps_pkg::PW_FACTORY && st_q == ST_LOAD ##17 settings_load_q) else $error("factory restore wrong"); // RL16
  store_locked_a: assert property (take && req.kind == nvmps_pkg::NVMPS_BEAT_SEND && req.code == nvmps_pkg::CMD_STORE_USER
    && !unlocked_q |=> req_nack_q && st_q == ST_IDLE) else $error("store while locked"); // RL18
  busy_block_a: assert property (st_q != ST_IDLE |-> !req_ready_q) else $error("request taken while busy"); // RL24
  csum_fault_a: assert property (st_q == ST_LOAD && walk_q == nvmps_pkg::WALK_CSUM
    |=> fault_q == ($past(acc_q) != $past(load_byte)) && csum_q == $past(acc_q)) else $error("checksum compare wrong"); // RL20

  unlock_seen_c: cover property (!unlocked_q ##1 unlocked_q);
  store_done_c: cover property (st_q == ST_STORE ##1 st_q == ST_WAIT);
  stalled_read_c: cover property (skid_v_q && out_v_q && !rsp_ready);

endmodule
`default_nettype wire

// *** core/nvmps_pkg.sv ***
package nvmps_pkg;

  // array geometry
  localparam int unsigned NUM_PAGES = 16;
  localparam int unsigned PAGE_BYTES = 512;
  localparam int unsigned MEM_BYTES = NUM_PAGES * PAGE_BYTES;
  localparam int unsigned SET_BYTES = 16;
  localparam int unsigned SET_BITS = SET_BYTES * 8;

  // command codes, also the register offsets
  localparam logic [15:0] OFF_PAGE_DATA_LO = 16'h00b0;
  localparam logic [15:0] OFF_PAGE_DATA_HI = 16'h00bf;
  localparam logic [15:0] OFF_CHECKSUM = 16'h00d1;
  localparam logic [15:0] OFF_RD_COUNT = 16'h00d2;
  localparam logic [15:0] OFF_BYTE_OFFSET = 16'h00d3;
  localparam logic [15:0] OFF_PAGE_ERASE = 16'h00d4;
  localparam logic [15:0] OFF_PASSWORD = 16'h00d5;
  localparam logic [15:0] OFF_STATUS_FLAGS = 16'hfe81;
  localparam logic [15:0] CMD_RESTORE_FACTORY = 16'h0012;
  localparam logic [15:0] CMD_STORE_USER = 16'h0015;
  localparam logic [15:0] CMD_RESTORE_USER = 16'h0016;

  // status flag bit positions
  localparam int unsigned FLAG_UNLOCKED_BIT = 6;
  localparam int unsigned FLAG_CSUM_FAULT_BIT = 5;

  // reset and fixed values
  localparam logic [7:0] PW_POWERUP = 8'h00;
  localparam logic [7:0] PW_FACTORY = 8'hff;
  localparam logic [7:0] INVALID_BYTE = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] RD_COUNT_RESET = 8'h01;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [3:0] FACTORY_PAGE = 4'h0;
  localparam logic [3:0] USER_PAGE = 4'h1;
  localparam logic [3:0] FIRST_OPEN_PAGE = 4'h2;
  localparam logic [8:0] MAX_BLOCK_BYTES = 9'h100;
  localparam logic [9:0] WALK_ERASE_LAST = 10'h1ff;
  localparam logic [9:0] WALK_CSUM = 10'h010;

  // busy time after erase or store
  localparam int unsigned ERASE_TIME_MS = 35;
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned BUSY_CYCLES_DEF = ERASE_TIME_MS * CLK_KHZ;

  typedef logic [22:0] nvmps_tmr_t;

  typedef enum logic [1:0] {
    NVMPS_BEAT_WRITE,
    NVMPS_BEAT_SEND,
    NVMPS_BEAT_READ
  } nvmps_kind_t;

  typedef struct packed {
    nvmps_kind_t kind;
    logic first;
    logic [15:0] code;
    logic [7:0] data;
  } nvmps_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } nvmps_rsp_t;

endpackage

// *** tb/nvmps_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// host side of the request and response channels; every wait is bounded
module nvmps_host_model (
  input wire logic ref_clk,
  output logic req_valid,
  output nvmps_pkg::nvmps_req_t req,
  input wire logic req_ready,
  input wire logic req_nack,
  input wire logic rsp_valid,
  input wire nvmps_pkg::nvmps_rsp_t rsp,
  output logic rsp_ready
);
  int timeouts = 0;
  bit stall = 1'b0;
  logic [7:0] got[$];

  initial begin
    req_valid = 1'b0;
    req = '0;
    rsp_ready = 1'b1;
  end

  // stalling host drops ready every other cycle, so the buffer must hold words
  always @(posedge ref_clk) begin
    #1 rsp_ready = stall ? ~rsp_ready : 1'b1;
  end

  // one beat: held until the edge that takes it; waiting on ready also covers busy time
  task automatic beat(input nvmps_pkg::nvmps_kind_t k, input logic f, input logic [15:0] c,
                      input logic [7:0] d, output logic nack);
    int n;
    n = 0;
    nack = 1'b0;
    @(posedge ref_clk);
    #1;
    req_valid = 1'b1;
    req = '{kind: k, first: f, code: c, data: d};
    // ready is looked at mid-cycle, where it equals what the next rising edge samples
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 6000);
    if (n >= 6000) timeouts++;
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    req.data = ~d;
    // the refusal pulse stands for the cycle right after the taking edge
    if (k != nvmps_pkg::NVMPS_BEAT_READ) begin
      nack = (req_nack === 1'b1);
    end
  endtask

  // read collects bytes until last; count never set above 256 by the bench
  task automatic rd(input logic [15:0] c);
    int n;
    logic nk;
    got.delete();
    beat(nvmps_pkg::NVMPS_BEAT_READ, 1'b0, c, 8'h00, nk);
    for (n = 0; n < 3000; n++) begin
      @(negedge ref_clk);
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        got.push_back(rsp.data);
        if (rsp.last === 1'b1) break;
      end
    end
    if (n >= 3000) timeouts++;
  endtask
endmodule
`default_nettype wire

// *** tb/nvmps_page_store_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module nvmps_page_store_tb_top;
  localparam logic [127:0] PATTERN = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid, req_ready, req_nack, rsp_valid, rsp_ready, settings_load;
  nvmps_pkg::nvmps_req_t req;
  nvmps_pkg::nvmps_rsp_t rsp;
  logic [127:0] settings_cur = PATTERN;
  logic [127:0] settings;
  int fail_count = 0;
  int n_compared = 0;
  int loads = 0;
  logic nk;

  nvmps_page_store #(.BUSY_CYCLES(20)) i_nvmps_page_store (.ref_clk(ref_clk), .reset(reset),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .req_nack(req_nack),
    .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready), .settings_cur(settings_cur),
    .settings(settings), .settings_load(settings_load));
  nvmps_host_model i_nvmps_host_model (.ref_clk(ref_clk), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .req_nack(req_nack), .rsp_valid(rsp_valid), .rsp(rsp),
    .rsp_ready(rsp_ready));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // count completed downloads
  always @(negedge ref_clk) begin
    if (settings_load === 1'b1) loads++;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // multi-byte write transaction; nack of any byte is reported
  task automatic wr(input logic [15:0] c, input logic [7:0] d[$], output logic nack);
    logic b;
    nack = 1'b0;
    foreach (d[i]) begin
      i_nvmps_host_model.beat(nvmps_pkg::NVMPS_BEAT_WRITE, i == 0, c, d[i], b);
      nack = nack | b;
    end
  endtask

  task automatic send(input logic [15:0] c, output logic nack);
    i_nvmps_host_model.beat(nvmps_pkg::NVMPS_BEAT_SEND, 1'b0, c, 8'h00, nack);
  endtask

  function automatic logic [7:0] byte0();
    return (i_nvmps_host_model.got.size() > 0) ? i_nvmps_host_model.got[0] : 8'hxx;
  endfunction

  task automatic flags(output logic [7:0] f);
    i_nvmps_host_model.rd(nvmps_pkg::OFF_STATUS_FLAGS);
    f = byte0();
  endtask

  task automatic give_verdict();
    fail_count += i_nvmps_host_model.timeouts;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    logic [7:0] f;
    int l0;
    repeat (5) @(posedge ref_clk);
    #1 reset = 1'b0;
    // locked after power-up
    flags(f);
    check(f[6], 1'b0);
    i_nvmps_host_model.rd(16'h00b0);
    check(byte0(), 8'hff);
    wr(16'h00b2, {8'h11}, nk);
    check(nk, 1'b1);
    wr(16'h00d4, {8'h02}, nk);
    check(nk, 1'b1);
    $display("test locked done");
    // unlock with two correct passwords
    wr(16'h00d5, {8'h00}, nk);
    wr(16'h00d5, {8'h00}, nk);
    flags(f);
    check(f[6], 1'b1);
    $display("test unlock done");
    // erase, write at offset, program again, read back with stalls
    wr(16'h00d4, {8'h01}, nk);
    check(nk, 1'b1);
    wr(16'h00d4, {8'h02}, nk);
    check(nk, 1'b0);
    wr(16'h00d3, {8'h05, 8'h00}, nk);
    wr(16'h00b2, {8'ha5, 8'h3c, 8'hf0}, nk);
    check(nk, 1'b0);
    wr(16'h00b2, {8'h0f}, nk);
    wr(16'h00d2, {8'h04}, nk);
    i_nvmps_host_model.stall = 1'b1;
    i_nvmps_host_model.rd(16'h00b2);
    i_nvmps_host_model.stall = 1'b0;
    check(i_nvmps_host_model.got.size(), 4);
    check({i_nvmps_host_model.got[0], i_nvmps_host_model.got[1]}, 16'h053c);
    check({i_nvmps_host_model.got[2], i_nvmps_host_model.got[3]}, 16'hf0ff);
    wr(16'h00b0, {8'h00}, nk);
    check(nk, 1'b1);
    $display("test page data done");
    // store the image, then download it again
    send(nvmps_pkg::CMD_STORE_USER, nk);
    check(nk, 1'b0);
    l0 = loads;
    send(nvmps_pkg::CMD_RESTORE_USER, nk);
    i_nvmps_host_model.rd(nvmps_pkg::OFF_CHECKSUM);
    check(byte0(), 8'h40);
    check(settings, PATTERN);
    check(loads - l0, 1);
    flags(f);
    check(f[5], 1'b0);
    wr(16'h00d3, {8'h10, 8'h00}, nk);
    wr(16'h00d2, {8'h01}, nk);
    i_nvmps_host_model.rd(16'h00b1);
    check(byte0(), 8'h40);
    $display("test settings done");
    // change, lock, unlock with the new password
    wr(16'h00d5, {8'h00}, nk);
    wr(16'h00d5, {8'h5a}, nk);
    wr(16'h00d5, {8'h33}, nk);
    flags(f);
    check(f[6], 1'b0);
    send(nvmps_pkg::CMD_STORE_USER, nk);
    check(nk, 1'b1);
    wr(16'h00d5, {8'h5a}, nk);
    wr(16'h00d5, {8'h5a}, nk);
    flags(f);
    check(f[6], 1'b1);
    // factory restore puts the password back to ff
    send(nvmps_pkg::CMD_RESTORE_FACTORY, nk);
    wr(16'h00d5, {8'h22}, nk);
    wr(16'h00d5, {8'hff}, nk);
    wr(16'h00d5, {8'hff}, nk);
    flags(f);
    check(f[6], 1'b1);
    $display("test password done");
    give_verdict();
  end
endmodule
`default_nettype wire
